// file: common/mar_defs.svh
// Constants for the measurement archive recorder
`ifndef MAR_DEFS_SVH
`define MAR_DEFS_SVH
`define MAR_GAS_HOUR_DEF     5'h06
`define MAR_PERIOD_MIN_S     12'h001
`define MAR_PERIOD_MAX_S     12'he10
`define MAR_PERIOD_DEF_S     12'he10
`define MAR_CLK_HZ           50000000
`define MAR_STAT_W           64
`define MAR_TICK_W           26
`define MAR_SEC_W            32
`define MAR_KIND_MONTH       3'h0
`define MAR_KIND_DAY         3'h1
`define MAR_KIND_DATA        3'h2
`define MAR_KIND_BIN         3'h3
`define MAR_KIND_LIMIT       3'h4
`define MAR_KIND_STATUS      3'h5
`endif

// file: common/mar_pkg.sv
// Types shared by the measurement archive recorder
package mar_pkg;
  // Calendar time of a slot, one second resolution
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } mar_time_type;

  // One record as offered to the memory writer
  typedef struct packed {
    logic [2:0]   kind;
    logic [11:0]  addr;
    mar_time_type stamp;
    logic [31:0]  value;
    logic [31:0]  aux;
    mar_time_type aux_stamp;
    logic [63:0]  flags;
  } mar_rec_type;

  typedef enum logic [2:0] {
    MAR_IDLE,
    MAR_MONTH,
    MAR_DAY,
    MAR_DATA,
    MAR_BIN,
    MAR_STATUS
  } mar_state_type;
endpackage

// file: hdl/mar_minmax.sv
// Minimum and maximum tracker with time of reaching
`timescale 1ns/10ps
module mar_minmax
  import mar_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         init,
  input  wire logic         sample,
  input  wire logic [31:0]  value,
  input  mar_time_type      now,
  output logic [31:0]       min_v,
  output logic [31:0]       max_v,
  output mar_time_type      min_t,
  output mar_time_type      max_t,
  output logic              changed
);
  logic [31:0]  min_r;
  logic [31:0]  max_r;
  mar_time_type min_t_r;
  mar_time_type max_t_r;
  logic         chg_r;

  // ====================================================
  // Load both holders on init, else track extremes
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      min_r   <= 32'h0000_0000;
      max_r   <= 32'h0000_0000;
      min_t_r <= '0;
      max_t_r <= '0;
      chg_r   <= 1'b0;
    end
    else if (init)
    begin
      min_r   <= value;
      max_r   <= value;
      min_t_r <= now;
      max_t_r <= now;
      chg_r   <= 1'b1;
    end
    else
    begin
      chg_r <= 1'b0;
      if (sample && value < min_r)
      begin
        min_r   <= value;
        min_t_r <= now;
        chg_r   <= 1'b1;
      end
      if (sample && value > max_r)
      begin
        max_r   <= value;
        max_t_r <= now;
        chg_r   <= 1'b1;
      end
    end
  end

  assign min_v   = min_r;
  assign max_v   = max_r;
  assign min_t   = min_t_r;
  assign max_t   = max_t_r;
  assign changed = chg_r;
endmodule

// file: hdl/mar_recorder.sv
// Measurement archive recorder top level
//
// Overview of operation
// - Every record except the limit record carries its slot time; all but binary records carry selected quantity values.
// - Fixed archives sit at memory start; data archive takes the remainder.
// - Monthly archive writes once a month at the gas hour.
// - Monthly records carry their own record timestamp.
// - Full fixed archives overwrite their oldest record.
// - Monthly statistics cover the span since the previous monthly record.
// - Daily archive writes once a day at the gas hour, except on the gas hour that writes a monthly record; same statistics.
// - Data archive period is programmable from one second to one hour.
// - Data archive period defaults to one hour after initialisation.
// - Status bits in data records are sticky per archive period.
// - Setpoints and errors active high; binary input polarity is configurable.
// - Binary archive stores binary inputs, status bits and device errors.
// - Binary archive writes only when an archived binary signal changes.
// - Binary records carry a one second resolution timestamp.
// - Limit archive keeps min and max with their time of reaching.
// - On limit initialisation min and max load the current value.
// - Status archive records time, 64-bit event word and primary volume.
// - Maximum hourly and daily consumption keep their hour or day.
// - Mean values go to data, daily, monthly archives, not limit or binary.
`timescale 1ns/10ps
`include "mar_defs.svh"
module mar_recorder
  import mar_pkg::*;
#(
  parameter int MEM_WORDS   = 4096,
  parameter int MONTH_DEPTH = 24,
  parameter int DAY_DEPTH   = 400,
  parameter int BIN_DEPTH   = 512,
  parameter int LIMIT_DEPTH = 2,
  parameter int STATUS_DEPTH = 256,
  parameter int CLK_HZ      = `MAR_CLK_HZ
)
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  mar_time_type      now,
  input  wire logic [4:0]   gas_hour,
  input  wire logic         period_load,
  input  wire logic [11:0]  period_s,
  input  wire logic         limit_init,
  input  wire logic [31:0]  analog_value,
  input  wire logic [31:0]  primary_volume_counter_one,
  input  wire logic [15:0]  bin_inputs,
  input  wire logic [15:0]  bin_polarity,
  input  wire logic [15:0]  setpoints,
  input  wire logic [15:0]  dev_errors,
  input  wire logic [15:0]  status_bits,
  input  wire logic [63:0]  event_word,
  output mar_rec_type       rec,
  output logic              rec_valid,
  output logic [11:0]       period_cur
);
  localparam int FIXED_WORDS = MONTH_DEPTH + DAY_DEPTH + BIN_DEPTH + LIMIT_DEPTH + STATUS_DEPTH;
  localparam int DATA_DEPTH  = MEM_WORDS - FIXED_WORDS;
  localparam int TICK_DIV    = CLK_HZ;
  localparam int B_DAY       = MONTH_DEPTH;
  localparam int B_BIN       = B_DAY + DAY_DEPTH;
  localparam int B_LIMIT     = B_BIN + BIN_DEPTH;
  localparam int B_STATUS    = B_LIMIT + LIMIT_DEPTH;
  localparam int B_DATA      = B_STATUS + STATUS_DEPTH;

  initial
  begin
    if (MEM_WORDS > 4096 || DATA_DEPTH < 1)
      $error("mar_recorder: memory too small for fixed archives");
    if (CLK_HZ < 2 || CLK_HZ >= (1 << `MAR_TICK_W))
      $error("mar_recorder: clock rate out of range");
  end

  // Adds with saturation, used by all accumulators
  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[32] ? 32'hffff_ffff : s[31:0];
  endfunction

  // Archived binary vector in active-high form
  function automatic logic [63:0] bin_vec(input logic [15:0] bi, input logic [15:0] pol,
                                          input logic [15:0] sp, input logic [15:0] er,
                                          input logic [15:0] st);
    bin_vec = {st, er, sp, bi ~^ pol};
  endfunction

  // ======================================================================
  // One second enable from the system clock
  logic [`MAR_TICK_W-1:0] tick_cnt_r;
  logic                   sec_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tick_cnt_r <= '0;
      sec_r      <= 1'b0;
    end
    else if (tick_cnt_r == `MAR_TICK_W'(TICK_DIV - 1))
    begin
      tick_cnt_r <= '0;
      sec_r      <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + `MAR_TICK_W'(1);
      sec_r      <= 1'b0;
    end
  end

  // ======================================================================
  // Data archive period register, clamped to the legal range
  logic [11:0] period_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      period_r <= `MAR_PERIOD_DEF_S;
    else if (period_load)
    begin
      if (period_s < `MAR_PERIOD_MIN_S)
        period_r <= `MAR_PERIOD_MIN_S;
      else if (period_s > `MAR_PERIOD_MAX_S)
        period_r <= `MAR_PERIOD_MAX_S;
      else
        period_r <= period_s;
    end
  end

  // ======================================================================
  // Data period seconds counter
  logic [11:0] per_cnt_r;
  logic        data_due_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      per_cnt_r  <= 12'h000;
      data_due_r <= 1'b0;
    end
    else
    begin
      data_due_r <= 1'b0;
      if (sec_r)
      begin
        if (per_cnt_r + 12'h001 >= period_r)
        begin
          per_cnt_r  <= 12'h000;
          data_due_r <= 1'b1;
        end
        else
          per_cnt_r <= per_cnt_r + 12'h001;
      end
    end
  end

  // ======================================================================
  // Gas hour detection, once per hour change into the gas hour
  logic [4:0] last_hour_r;
  logic [4:0] ended_hour_r;
  logic [3:0] last_month_r;
  logic       day_due_r;
  logic       month_due_r;
  logic       hour_edge_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      last_hour_r  <= 5'h00;
      ended_hour_r <= 5'h00;
      last_month_r <= 4'h0;
      day_due_r    <= 1'b0;
      month_due_r  <= 1'b0;
      hour_edge_r  <= 1'b0;
    end
    else
    begin
      last_hour_r <= now.hour;
      ended_hour_r <= last_hour_r; // Hour that closed at the last hour edge
      hour_edge_r <= (now.hour != last_hour_r);
      day_due_r   <= 1'b0;
      month_due_r <= 1'b0;
      if (now.hour != last_hour_r && now.hour == gas_hour)
      begin
        day_due_r <= 1'b1;
        if (now.month != last_month_r)
        begin
          month_due_r  <= 1'b1;
          last_month_r <= now.month;
        end
      end
    end
  end

  // ======================================================================
  // Hourly and daily consumption statistics from the primary volume
  logic [31:0]  vol_hour_base_r;
  logic [31:0]  vol_day_base_r;
  logic [31:0]  max_hour_d_r;
  logic [4:0]   max_hour_d_at_r;
  logic [31:0]  max_hour_m_r;
  mar_time_type max_hour_m_at_r;
  logic [31:0]  max_day_m_r;
  logic [4:0]   max_day_m_at_r;
  logic [31:0]  hour_use;
  logic [31:0]  day_use;
  assign hour_use = primary_volume_counter_one - vol_hour_base_r;
  assign day_use  = primary_volume_counter_one - vol_day_base_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      vol_hour_base_r <= 32'h0000_0000;
      vol_day_base_r  <= 32'h0000_0000;
      max_hour_d_r    <= 32'h0000_0000;
      max_hour_d_at_r <= 5'h00;
      max_hour_m_r    <= 32'h0000_0000;
      max_hour_m_at_r <= '0;
      max_day_m_r     <= 32'h0000_0000;
      max_day_m_at_r  <= 5'h00;
    end
    else
    begin
      if (hour_edge_r)
      begin
        vol_hour_base_r <= primary_volume_counter_one;
        if (hour_use > max_hour_d_r || day_due_r)
        begin
          max_hour_d_r    <= hour_use;
          max_hour_d_at_r <= ended_hour_r;
        end
        if (hour_use > max_hour_m_r || month_due_r)
        begin
          max_hour_m_r    <= hour_use;
          max_hour_m_at_r <= now;
        end
      end
      if (day_due_r)
      begin
        vol_day_base_r <= primary_volume_counter_one;
        if (day_use > max_day_m_r || month_due_r)
        begin
          max_day_m_r    <= day_use;
          max_day_m_at_r <= now.day;
        end
      end
    end
  end

  // ======================================================================
  // Mean-value accumulators for data, daily and monthly archives
  logic [31:0] acc_data_r;
  logic [31:0] acc_day_r;
  logic [31:0] acc_month_r;
  logic [15:0] n_data_r;
  logic [15:0] n_day_r;
  logic [15:0] n_month_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      acc_data_r  <= 32'h0000_0000;
      acc_day_r   <= 32'h0000_0000;
      acc_month_r <= 32'h0000_0000;
      n_data_r    <= 16'h0000;
      n_day_r     <= 16'h0000;
      n_month_r   <= 16'h0000;
    end
    else if (sec_r)
    begin
      acc_data_r  <= data_due_r  ? analog_value : sat_add(acc_data_r, analog_value);
      acc_day_r   <= day_due_r   ? analog_value : sat_add(acc_day_r, analog_value);
      acc_month_r <= month_due_r ? analog_value : sat_add(acc_month_r, analog_value);
      n_data_r    <= data_due_r  ? 16'h0001 : n_data_r + 16'h0001;
      n_day_r     <= day_due_r   ? 16'h0001 : n_day_r + 16'h0001;
      n_month_r   <= month_due_r ? 16'h0001 : n_month_r + 16'h0001;
    end
    else
    begin
      if (data_due_r)
      begin
        acc_data_r <= 32'h0000_0000;
        n_data_r   <= 16'h0000;
      end
      if (day_due_r)
      begin
        acc_day_r <= 32'h0000_0000;
        n_day_r   <= 16'h0000;
      end
      if (month_due_r)
      begin
        acc_month_r <= 32'h0000_0000;
        n_month_r   <= 16'h0000;
      end
    end
  end

  // ======================================================================
  // Sticky status flags per data period; a new event beats the clear
  logic [63:0] cur_bin;
  logic [63:0] sticky_r;
  logic [63:0] last_bin_r;
  logic        bin_chg_r;
  assign cur_bin = bin_vec(bin_inputs, bin_polarity, setpoints, dev_errors, status_bits);
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sticky_r <= 64'h0;
    else if (data_due_r)
      sticky_r <= cur_bin;
    else
      sticky_r <= sticky_r | cur_bin;
  end

  // Change detect on archived binaries
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      last_bin_r <= 64'h0;
      bin_chg_r  <= 1'b0;
    end
    else
    begin
      last_bin_r <= cur_bin;
      bin_chg_r  <= (cur_bin != last_bin_r);
    end
  end

  // Event word change detect for the status archive
  logic [63:0] last_evt_r;
  logic        evt_chg_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      last_evt_r <= 64'h0;
      evt_chg_r  <= 1'b0;
    end
    else
    begin
      last_evt_r <= event_word;
      evt_chg_r  <= (event_word != last_evt_r);
    end
  end

  // ======================================================================
  // Limit tracker and region pointers
  logic [31:0]  lim_min;
  logic [31:0]  lim_max;
  mar_time_type lim_min_t;
  mar_time_type lim_max_t;
  logic         lim_chg;
  mar_minmax u_minmax (
    .clk_sys (clk_sys),
    .reset   (reset),
    .init    (limit_init),
    .sample  (sec_r),
    .value   (analog_value),
    .now     (now),
    .min_v   (lim_min),
    .max_v   (lim_max),
    .min_t   (lim_min_t),
    .max_t   (lim_max_t),
    .changed (lim_chg)
  );

  logic [5:0]  adv;
  logic [11:0] a_month;
  logic [11:0] a_day;
  logic [11:0] a_bin;
  logic [11:0] a_stat;
  logic [11:0] a_data;
  mar_ring_ptr #(.BASE(0), .DEPTH(MONTH_DEPTH)) u_p_month (
    .clk_sys (clk_sys), .reset (reset), .adv (adv[0]), .addr (a_month), .full ());
  mar_ring_ptr #(.BASE(B_DAY), .DEPTH(DAY_DEPTH)) u_p_day (
    .clk_sys (clk_sys), .reset (reset), .adv (adv[1]), .addr (a_day), .full ());
  mar_ring_ptr #(.BASE(B_BIN), .DEPTH(BIN_DEPTH)) u_p_bin (
    .clk_sys (clk_sys), .reset (reset), .adv (adv[2]), .addr (a_bin), .full ());
  mar_ring_ptr #(.BASE(B_STATUS), .DEPTH(STATUS_DEPTH)) u_p_stat (
    .clk_sys (clk_sys), .reset (reset), .adv (adv[3]), .addr (a_stat), .full ());
  mar_ring_ptr #(.BASE(B_DATA), .DEPTH(DATA_DEPTH)) u_p_data (
    .clk_sys (clk_sys), .reset (reset), .adv (adv[4]), .addr (a_data), .full ());

  // ======================================================================
  // Record emitter, one record per cycle by fixed priority
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rec       <= '0;
      rec_valid <= 1'b0;
      adv       <= 6'h00;
    end
    else
    begin
      rec_valid       <= 1'b1;
      adv             <= 6'h00;
      rec.stamp       <= now;
      rec.aux_stamp   <= '0;
      rec.flags       <= 64'h0;
      rec.aux         <= 32'h0000_0000;
      if (month_due_r)
      begin
        rec.kind      <= `MAR_KIND_MONTH;
        rec.addr      <= a_month;
        rec.value     <= acc_month_r;
        rec.aux       <= max_day_m_r;
        rec.aux_stamp <= max_hour_m_at_r;
        rec.flags     <= {27'h0, max_day_m_at_r, max_hour_m_r};
        adv[0]        <= 1'b1;
      end
      else if (day_due_r)
      begin
        rec.kind      <= `MAR_KIND_DAY;
        rec.addr      <= a_day;
        rec.value     <= acc_day_r;
        rec.aux       <= max_hour_d_r;
        rec.flags     <= {59'h0, max_hour_d_at_r};
        adv[1]        <= 1'b1;
      end
      else if (data_due_r)
      begin
        rec.kind      <= `MAR_KIND_DATA;
        rec.addr      <= a_data;
        rec.value     <= acc_data_r;
        rec.aux       <= primary_volume_counter_one;
        rec.flags     <= sticky_r;
        adv[4]        <= 1'b1;
      end
      else if (evt_chg_r)
      begin
        rec.kind      <= `MAR_KIND_STATUS;
        rec.addr      <= a_stat;
        rec.value     <= primary_volume_counter_one;
        rec.flags     <= last_evt_r;
        adv[3]        <= 1'b1;
      end
      else if (bin_chg_r)
      begin
        rec.kind      <= `MAR_KIND_BIN;
        rec.addr      <= a_bin;
        rec.value     <= 32'h0000_0000;
        rec.flags     <= last_bin_r;
        adv[2]        <= 1'b1;
      end
      else if (lim_chg)
      begin
        rec.kind      <= `MAR_KIND_LIMIT;
        rec.addr      <= 12'(B_LIMIT);
        rec.value     <= lim_min;
        rec.aux       <= lim_max;
        rec.stamp     <= lim_min_t;
        rec.aux_stamp <= lim_max_t;
      end
      else
        rec_valid     <= 1'b0;
    end
  end

  // Registered copy of the data period for the outside
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      period_cur <= `MAR_PERIOD_DEF_S;
    else
      period_cur <= period_r;
  end

  // ======================================================================
  // Checks
  AST_PERIOD_RANGE: assert property (@(posedge clk_sys) disable iff (reset)
    period_r >= `MAR_PERIOD_MIN_S && period_r <= `MAR_PERIOD_MAX_S) else $error("period out of range");
  AST_PERIOD_DEF: assert property (@(posedge clk_sys)
    $fell(reset) |-> period_r == `MAR_PERIOD_DEF_S) else $error("period default wrong");
  AST_MONTH_REC: assert property (@(posedge clk_sys) disable iff (reset)
    month_due_r |=> rec_valid && rec.kind == `MAR_KIND_MONTH && rec.stamp == $past(now)) else $error("no month record");
  AST_DAY_REC: assert property (@(posedge clk_sys) disable iff (reset)
    day_due_r && !month_due_r |=> rec_valid && rec.kind == `MAR_KIND_DAY) else $error("no day record");
  AST_BIN_ONLY_ON_CHANGE: assert property (@(posedge clk_sys) disable iff (reset)
    rec_valid && rec.kind == `MAR_KIND_BIN |-> $past(bin_chg_r)) else $error("binary record without change");
  AST_STICKY: assert property (@(posedge clk_sys) disable iff (reset)
    !data_due_r && $past(!reset) |=> (sticky_r & $past(sticky_r)) == $past(sticky_r)) else $error("sticky lost");
  AST_STATUS_REC: assert property (@(posedge clk_sys) disable iff (reset)
    rec_valid && rec.kind == `MAR_KIND_STATUS |-> rec.value == $past(primary_volume_counter_one)) else $error("status volume");
  AST_ACC_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
    data_due_r && !sec_r |=> acc_data_r == 32'h0000_0000) else $error("accumulator not cleared");
  AST_LIMIT_INIT: assert property (@(posedge clk_sys) disable iff (reset)
    limit_init |=> lim_min == $past(analog_value) && lim_max == $past(analog_value)) else $error("limit init");
endmodule

// file: hdl/mar_ring_ptr.sv
// Circular write pointer for one archive region
`timescale 1ns/10ps
module mar_ring_ptr
  import mar_pkg::*;
#(
  parameter int BASE  = 0,
  parameter int DEPTH = 16
)
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        adv,
  output logic [11:0]      addr,
  output logic             full
);
  logic [11:0] idx_r;
  logic        full_r;

  initial
  begin
    if (DEPTH < 1 || BASE + DEPTH > 4096)
      $error("mar_ring_ptr: region does not fit");
  end

  // ====================================================
  // Pointer wraps so the oldest entry is overwritten
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      idx_r  <= 12'h000;
      full_r <= 1'b0;
    end
    else if (adv)
    begin
      if (idx_r == 12'(DEPTH - 1))
      begin
        idx_r  <= 12'h000;
        full_r <= 1'b1;
      end
      else
        idx_r <= idx_r + 12'h001;
    end
  end

  assign addr = 12'(BASE) + idx_r;
  assign full = full_r;
endmodule

// file: tb/testbench.sv
// Self-checking bench for the measurement archive recorder
`timescale 1ns/10ps
module testbench
  import mar_pkg::*;
;
  // ==========================================
  // Stimulus signals
  logic         clk_sys;
  logic         reset;
  mar_time_type now;
  logic [4:0]   gas_hour;
  logic         period_load;
  logic [11:0]  period_s;
  logic         limit_init;
  logic [31:0]  analog_value;
  logic [31:0]  primary_volume_counter_one;
  logic [15:0]  bin_inputs;
  logic [15:0]  bin_polarity;
  logic [15:0]  setpoints;
  logic [15:0]  dev_errors;
  logic [15:0]  status_bits;
  logic [63:0]  event_word;
  mar_rec_type  rec;
  logic         rec_valid;
  logic [11:0]  period_cur;
  int           n_errors;
  int           compares;
  int           cnt;
  mar_rec_type  r;
  logic [11:0]  p;

  // ==========================================
  // Design, seconds shortened to ten cycles
  mar_recorder #(.CLK_HZ(10)) dut (
    .clk_sys(clk_sys), .reset(reset), .now(now), .gas_hour(gas_hour),
    .period_load(period_load), .period_s(period_s), .limit_init(limit_init),
    .analog_value(analog_value), .primary_volume_counter_one(primary_volume_counter_one),
    .bin_inputs(bin_inputs), .bin_polarity(bin_polarity), .setpoints(setpoints),
    .dev_errors(dev_errors), .status_bits(status_bits), .event_word(event_word),
    .rec(rec), .rec_valid(rec_valid), .period_cur(period_cur));

  // ==========================================
  // Clock, 20 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Compare seen against expected and count
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Expected period after a load, held inside one second to one hour
  function automatic logic [11:0] clamp(input logic [11:0] v);
    if (v < 12'h001) return 12'h001;
    if (v > 12'he10) return 12'he10;
    return v;
  endfunction

  // Expected archived binary vector; an input is active when it equals its polarity
  function automatic logic [63:0] bin_exp();
    return {status_bits, dev_errors, setpoints, ~(bin_inputs ^ bin_polarity)};
  endfunction

  // Wait a bounded time for a record of one kind
  task automatic wait_kind(input logic [2:0] k, input int lim, output mar_rec_type o);
    int i;
    o = '0;
    for (i = 0; i < lim; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (rec_valid === 1'b1 && rec.kind === k)
      begin
        o = rec;
        return;
      end
    end
    check("record kind arrival", {61'h0, k} ^ 64'h1, {61'h0, k});
  endtask

  // Count records of one kind over a number of cycles
  task automatic count_kind(input logic [2:0] k, input int lim, output int c);
    c = 0;
    repeat (lim)
    begin
      @(posedge clk_sys);
      #1;
      if (rec_valid === 1'b1 && rec.kind === k) c++;
    end
  endtask

  // Load a data period
  task automatic load_period(input logic [11:0] v);
    @(posedge clk_sys);
    period_s    <= v;
    period_load <= 1'b1;
    @(posedge clk_sys);
    period_load <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("period_cur", period_cur, clamp(v));
  endtask

  // Watchdog
  initial
  begin
    #400000;
    n_errors++;
    final_report();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    n_errors = 0;
    compares = 0;
    void'($urandom(32'h40eb4177));
    reset = 1'b1;
    now = '{year: 7'h18, month: 4'h1, day: 5'h01, hour: 5'h00, minute: 6'h00, second: 6'h00};
    gas_hour = 5'h06;
    period_load = 1'b0;
    period_s = 12'h001;
    limit_init = 1'b0;
    analog_value = 32'h0000_1000;
    primary_volume_counter_one = $urandom;
    bin_inputs = 16'h0000;
    bin_polarity = 16'hffff;
    setpoints = 16'h0000;
    dev_errors = 16'h0000;
    status_bits = 16'h0000;
    event_word = 64'h0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("period_cur default", period_cur, 12'he10);
    // Clamp corners then random periods
    load_period(12'h000);
    load_period(12'hfa0);
    load_period(12'he10);
    repeat (3) load_period(12'((($urandom % 3600) + 1)));
    load_period(12'he10);
    // Binary changes, random vectors and polarities, then silence
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      bin_inputs <= 16'($urandom) | 16'h0001;
      bin_polarity <= 16'($urandom);
      setpoints  <= 16'($urandom);
      dev_errors <= 16'($urandom);
      wait_kind(3'h3, 20, r);
      check("binary flags", r.flags, bin_exp());
      check("binary stamp", r.stamp, now);
      check("binary addr", r.addr, 12'h1a8 + 12'(i));
      count_kind(3'h3, 30, cnt);
      check("binary quiet", 64'(cnt), 64'h0);
    end
    // Event word change
    @(posedge clk_sys);
    event_word <= {$urandom, $urandom};
    wait_kind(3'h5, 20, r);
    check("status word", r.flags, event_word);
    check("status volume", r.value, primary_volume_counter_one);
    check("status stamp", r.stamp, now);
    check("status addr", r.addr, 12'h3aa);
    // Gas hour of a new month
    @(posedge clk_sys);
    now.hour <= gas_hour;
    wait_kind(3'h0, 20, r);
    check("month stamp", r.stamp, now);
    check("month addr", r.addr, 12'h000);
    // Next day at gas hour gives a daily record
    @(posedge clk_sys);
    now.hour <= 5'h07;
    repeat (5) @(posedge clk_sys);
    now.day  <= 5'h02;
    now.hour <= 5'h05;
    repeat (5) @(posedge clk_sys);
    now.hour <= gas_hour;
    wait_kind(3'h1, 20, r);
    check("day stamp", r.stamp, now);
    check("day addr", r.addr, 12'h018);
    // Limit initialisation loads both holders with the present value
    @(posedge clk_sys);
    analog_value <= $urandom;
    limit_init   <= 1'b1;
    @(posedge clk_sys);
    limit_init   <= 1'b0;
    wait_kind(3'h4, 20, r);
    check("limit min", r.value, analog_value);
    check("limit max", r.aux, analog_value);
    check("limit stamp", r.stamp, now);
    // Short data period, count records in a window
    for (int q = 1; q <= 3; q++)
    begin
      p = 12'(q);
      load_period(p);
      count_kind(3'h2, 40 * q, cnt);
      check("data record count", 64'((cnt >= 3) && (cnt <= 5)), 64'h1);
    end
    wait_kind(3'h2, 40, r);
    check("data flags", r.flags, bin_exp());
    final_report();
  end
endmodule
